// ### hdl/tccu_pkg.sv
// Purpose: Shared constants and types for the timer capture/compare unit
// Assumes: APB word registers, byte address is four times the index
// Notes:   Mode codes follow the unit_mode_select field encoding
package tccu_pkg;

    // Register indices; byte address = index * 4
    localparam logic [7:0] IDX_CAPTURE_VALUE_LOW  = 8'h15;
    localparam logic [7:0] IDX_CAPTURE_VALUE_HIGH = 8'h16;
    localparam logic [7:0] IDX_CAPTURE_COMPARE_CONTROL = 8'h17;
    localparam logic [7:0] IDX_UNIT_EVENT_STATUS  = 8'h18;

    // Field positions of capture_compare_control and of the status register
    localparam int CTRL_MODE_LSB      = 0;
    localparam int CTRL_DUTY_LSB_LOWER = 4;
    localparam int CTRL_DUTY_LSB_UPPER = 5;
    localparam int STATUS_FLAG_BIT    = 0;

    // Values after reset
    localparam logic [5:0]  CTRL_RESET    = 6'h00;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;
    localparam logic [3:0]  PRESC_RESET   = 4'h0;

    // Mode codes
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET   = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT  = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG  = 4'hB;
    localparam logic [1:0] GROUP_CAPTURE  = 2'b01;
    localparam logic [1:0] GROUP_COMPARE  = 2'b10;

    // Prescaler masks: capture when the counted edges fill the mask
    localparam logic [3:0] MASK_EVERY1  = 4'h0;
    localparam logic [3:0] MASK_EVERY4  = 4'h3;
    localparam logic [3:0] MASK_EVERY16 = 4'hF;

    typedef struct packed {
        logic       duty_lsb_upper;
        logic       duty_lsb_lower;
        logic [3:0] unit_mode_select;
    } tccu_ctrl_s;

endpackage : tccu_pkg

// ### hdl/tccu_top.sv
// Purpose: Timer capture/compare unit with APB register access
// Assumes: timer_count and port inputs are on pclk; unit_pin_in is async
// Notes:   PWM datapath lives elsewhere; only duty LSB storage is kept
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module tccu_top #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, freeze
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Reference timer
    input  wire logic [15:0]       timer_count,
    output logic                   timer_reset,
    output logic                   conversion_start,
    // Unit pin and port
    input  wire logic              unit_pin_in,
    output logic                   unit_pin_out,
    output logic                   unit_pin_oe_n,
    input  wire logic              port_direction,
    input  wire logic              port_data_latch,
    // Status
    output logic                   unit_event_flag
);

    if (ADDR_W < 7 || ADDR_W > 32)
    begin : g_addr_check
        $error("tccu_top: ADDR_W must lie in 7..32");
    end

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [7:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        return a == byte_addr;
    endfunction : addr_hit

    function automatic logic [3:0] presc_mask(input logic [3:0] m);
        logic [3:0] r;
        r = tccu_pkg::MASK_EVERY1;
        case (m)
            tccu_pkg::MODE_CAP_RISE4:  r = tccu_pkg::MASK_EVERY4;
            tccu_pkg::MODE_CAP_RISE16: r = tccu_pkg::MASK_EVERY16;
            default:                   r = tccu_pkg::MASK_EVERY1;
        endcase
        return r;
    endfunction : presc_mask

    tccu_pkg::tccu_ctrl_s ctrl;
    logic [15:0]          cap_value;
    logic [3:0]           presc;
    logic                 pin_s1;
    logic                 pin_s2;
    logic                 pin_s3;
    logic                 pin_level;
    logic                 src_q;
    logic                 match_q;
    logic                 cmp_latch;

    // Bus decode
    wire setup_acc = psel & penable & ~pready;
    wire access    = psel & penable & pready;
    wire wr        = access & pwrite;
    wire hit_low   = addr_hit(paddr, tccu_pkg::IDX_CAPTURE_VALUE_LOW);
    wire hit_high  = addr_hit(paddr, tccu_pkg::IDX_CAPTURE_VALUE_HIGH);
    wire hit_ctrl  = addr_hit(paddr, tccu_pkg::IDX_CAPTURE_COMPARE_CONTROL);
    wire hit_stat  = addr_hit(paddr, tccu_pkg::IDX_UNIT_EVENT_STATUS);
    wire hit_any   = hit_low | hit_high | hit_ctrl | hit_stat;
    wire wr_low    = wr & hit_low;
    wire wr_high   = wr & hit_high;
    wire wr_ctrl   = wr & hit_ctrl;
    wire wr_clear  = wr & hit_stat & pwdata[tccu_pkg::STATUS_FLAG_BIT];
    // Bits 7-6 are unimplemented, so only 5-0 decide a zero write
    wire ctrl_zero_write = wr_ctrl & (pwdata[5:0] == 6'h00);

    wire [3:0] mode = ctrl.unit_mode_select;
    wire is_capture = mode[3:2] == tccu_pkg::GROUP_CAPTURE;
    wire is_compare = mode[3:2] == tccu_pkg::GROUP_COMPARE;

    // Output pin shows the port latch, so its toggles are edges too
    wire cap_src = port_direction ? pin_level : port_data_latch;
    wire rise    = cap_src & ~src_q;
    wire fall    = ~cap_src & src_q;
    wire [3:0] mask = presc_mask(mode);
    wire rise_evt = rise & ((presc & mask) == mask);
    wire cap_evt  = is_capture &
                    ((mode == tccu_pkg::MODE_CAP_FALL) ? fall
                                                       : rise_evt);

    // Edge history survives switches between capture modes; stale edges may flag
    wire [3:0] next_presc = !is_capture ? tccu_pkg::PRESC_RESET
                          : rise ? presc + 4'h1 : presc;

    wire match   = is_compare & (timer_count == cap_value);
    // A stalled timer holds equality; act once per arrival
    wire cmp_hit = match & ~match_q;
    wire is_set  = mode == tccu_pkg::MODE_CMP_SET;
    wire is_clr  = mode == tccu_pkg::MODE_CMP_CLR;
    wire is_trig = mode == tccu_pkg::MODE_CMP_TRIG;
    wire next_cmp_latch = ctrl_zero_write       ? 1'b0
                        : (cmp_hit & is_set)    ? 1'b1
                        : (cmp_hit & is_clr)    ? 1'b0
                        : cmp_latch;
    wire next_pin_out = is_compare ? next_cmp_latch : port_data_latch;

    // Set beats a same-cycle software clear
    wire next_flag = cap_evt | cmp_hit |
                     (unit_event_flag & ~wr_clear);

    wire [15:0] next_cap_value =
        cap_evt ? timer_count
      : {wr_high ? pwdata[7:0] : cap_value[15:8],
         wr_low  ? pwdata[7:0] : cap_value[7:0]};

    // Duty LSBs are stored in every mode, used only by PWM
    wire [5:0] ctrl_bits = ctrl;
    wire [31:0] read_word =
        hit_low  ? {24'h000000, cap_value[7:0]}
      : hit_high ? {24'h000000, cap_value[15:8]}
      : hit_ctrl ? {26'h0000000, ctrl_bits}
      : hit_stat ? {31'h00000000, unit_event_flag}
      : 32'h00000000;

    // Pin synchroniser; a change counts once stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_s3    <= 1'b0;
            pin_level <= 1'b0;
        end
        else if (ce)
        begin
            pin_s1 <= unit_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3)
                pin_level <= pin_s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl      <= tccu_pkg::CTRL_RESET;
            cap_value <= tccu_pkg::VALUE_RESET;
            presc     <= tccu_pkg::PRESC_RESET;
            src_q     <= 1'b0;
            match_q   <= 1'b0;
            cmp_latch <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl <= pwdata[5:0];
            cap_value <= next_cap_value;
            presc     <= next_presc;
            src_q     <= cap_src;
            match_q   <= match;
            cmp_latch <= next_cmp_latch;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unit_event_flag  <= 1'b0;
            unit_pin_out     <= 1'b0;
            unit_pin_oe_n    <= 1'b1;
            timer_reset      <= 1'b0;
            conversion_start <= 1'b0;
        end
        else if (ce)
        begin
            unit_event_flag  <= next_flag;
            unit_pin_out     <= next_pin_out;
            unit_pin_oe_n    <= port_direction;
            // Trigger has no path to the timer overflow flag
            timer_reset      <= cmp_hit & is_trig;
            conversion_start <= cmp_hit & is_trig;
        end
    end

    // One wait state: ready rises the cycle after access begins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= setup_acc;
            prdata  <= (setup_acc & ~pwrite) ? read_word : 32'h00000000;
            pslverr <= setup_acc & ~hit_any;
        end
    end

    cap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cap_evt |=> unit_event_flag)
        else $error("capture did not set the event flag");

    cap_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cap_evt |=> cap_value == $past(timer_count))
        else $error("captured value differs from timer count");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        unit_event_flag && !(ce && wr_clear) |=> unit_event_flag)
        else $error("event flag dropped without software clear");

    presc_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !is_capture |=> presc == 4'h0)
        else $error("prescaler not held at zero");

    every_four_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && mode == tccu_pkg::MODE_CAP_RISE4 && rise && presc[1:0] != 2'h3
        |-> !cap_evt)
        else $error("capture before fourth rising edge");

    cmp_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cmp_hit && is_set && !ctrl_zero_write
        |=> unit_pin_out && unit_event_flag)
        else $error("set-on-match pin and flag not together");

    cmp_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cmp_hit && is_clr |=> !unit_pin_out && unit_event_flag)
        else $error("clear-on-match pin or flag wrong");

    cmp_soft_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cmp_hit && mode == tccu_pkg::MODE_CMP_SOFT && !ctrl_zero_write
        |=> cmp_latch == $past(cmp_latch) && unit_event_flag)
        else $error("software match mode moved the pin");

    trig_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cmp_hit && is_trig |=> timer_reset && conversion_start)
        else $error("special trigger missing on match");

    zero_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ctrl_zero_write |=> !cmp_latch)
        else $error("zero control write left compare latch high");

    ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup_acc && !pwrite && hit_ctrl |=> prdata[31:6] == 26'h0)
        else $error("control upper bits not read as zero");

    // A frozen answer cycle keeps ready up, so look at last cycle's ce
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup_acc |=> pready ##1 (!pready || !$past(ce)))
        else $error("ready not a single-cycle answer");

    slverr_map_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && setup_acc && !hit_any
        |=> pready && pslverr)
        else $error("unmapped access answered without error");

    presc_count_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && is_capture && rise
        |=> presc == $past(presc) + 4'h1)
        else $error("prescaler missed a rising edge");

    presc_keep_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && is_capture && !rise
        |=> presc == $past(presc))
        else $error("prescaler moved without an edge");

    rise_every_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && mode == tccu_pkg::MODE_CAP_RISE
        && rise |-> cap_evt)
        else $error("rising edge not captured");

    every_sixteen_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && mode == tccu_pkg::MODE_CAP_RISE16
        && rise && presc != 4'hF |-> !cap_evt)
        else $error("capture before sixteenth rising edge");

    fall_every_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && mode == tccu_pkg::MODE_CAP_FALL
        && fall |-> cap_evt)
        else $error("falling edge not captured");

    off_quiet_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && mode == tccu_pkg::MODE_OFF
        |-> !cap_evt && !cmp_hit)
        else $error("unit acted while off");

    pwm_quiet_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && mode[3:2] == 2'h3
        |-> !cap_evt && !cmp_hit)
        else $error("capture or compare in pulse width mode");

    ctrl_store_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && wr_ctrl
        |=> ctrl_bits == $past(pwdata[5:0]))
        else $error("control bits not stored");

    cap_wins_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && cap_evt && (wr_low || wr_high)
        |=> cap_value == $past(timer_count))
        else $error("software write beat a capture");

    flag_clear_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && wr_clear && !cap_evt && !cmp_hit
        |=> !unit_event_flag)
        else $error("software clear left the flag set");

    cmp_equal_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && is_compare && !match_q
        && timer_count == cap_value |-> cmp_hit)
        else $error("equality not detected");

    trig_quiet_a: assert property (@(posedge pclk)
        disable iff (!presetn) ce && !(cmp_hit && is_trig)
        |=> !timer_reset && !conversion_start)
        else $error("special trigger without a match");

endmodule : tccu_top

// ### verification/tccu_pin_src.sv
// Purpose: Edge source standing on the unit pin
// Assumes: Driven just after pclk edges; pin idles low between bursts
// Notes:   Level length is random, so edges come slow or prompt
`timescale 1ns/1ps
module tccu_pin_src (
    // Clock and pin
    input  wire logic pclk,
    output logic      pin
);
    initial pin = 1'b0;

    // At least 6 cycles a level, past the 3-flop synchroniser
    task automatic pulses(input int n);
        int g;
        for (int i = 0; i < n; i++)
        begin
            g = 6 + int'($urandom % 4);
            repeat (g) @(posedge pclk);
            pin <= 1'b1;
            repeat (g) @(posedge pclk);
            pin <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask : pulses
endmodule : tccu_pin_src

// ### verification/tccu_bench.sv
// Purpose: Self-checking bench for the capture/compare unit
// Assumes: ce held high; reference timer modelled here
// Notes:   APB results are queued and checked by a pready monitor
`timescale 1ns/1ps
module tccu_bench;
    localparam logic [7:0] LO = tccu_pkg::IDX_CAPTURE_VALUE_LOW;
    localparam logic [7:0] HI = tccu_pkg::IDX_CAPTURE_VALUE_HIGH;
    localparam logic [7:0] CT = tccu_pkg::IDX_CAPTURE_COMPARE_CONTROL;
    localparam logic [7:0] ST = tccu_pkg::IDX_UNIT_EVENT_STATUS;
    localparam logic [3:0] MD [5] = '{tccu_pkg::MODE_CMP_SET,
        tccu_pkg::MODE_CMP_SOFT, tccu_pkg::MODE_CMP_CLR,
        tccu_pkg::MODE_CMP_TRIG, tccu_pkg::MODE_CMP_SET};
    localparam logic [4:0] PX = 5'b10011;
    logic        pclk, presetn, ce, psel, penable, pwrite, load, run;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, timer_reset, conversion_start;
    logic        unit_pin_in, unit_pin_out, unit_pin_oe_n;
    logic        port_direction, port_data_latch, unit_event_flag;
    logic [15:0] timer_count, load_val, t, c;
    logic [33:0] e;
    logic [33:0] expq [$];
    int          err_total, cmp_count, trig_cnt, cycles, n;

    tccu_top #(.ADDR_W(8)) tccu_top_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_count(timer_count),
        .timer_reset(timer_reset), .conversion_start(conversion_start),
        .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out),
        .unit_pin_oe_n(unit_pin_oe_n), .port_direction(port_direction),
        .port_data_latch(port_data_latch),
        .unit_event_flag(unit_event_flag));
    tccu_pin_src tccu_pin_src_inst (.pclk(pclk), .pin(unit_pin_in));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task report_and_stop;
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // Synchronous counter only; an async timer may miss events
    always @(posedge pclk)
    begin
        if (!presetn)
            timer_count <= 16'h0000;
        else if (load)
            timer_count <= load_val;
        else if (timer_reset === 1'b1)
            timer_count <= 16'h0000;
        else if (run)
            timer_count <= timer_count + 16'h0001;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (pready === 1'b1)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 34'h3FFFFFFFF;
            chk(32'(pslverr), 32'(e[32]));
            if (e[33])
                chk(prdata, e[31:0]);
        end
        if (timer_reset === 1'b1)
            trig_cnt++;
        if ((timer_reset | conversion_start) !== 1'b0)
            chk(32'(timer_reset), 32'(conversion_start));
        if (cycles > 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic apb(input logic wr, input logic [7:0] i,
                       input logic [31:0] d, input logic [33:0] x);
        expq.push_back(x);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {i[5:0], 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, i, d, 34'h0);
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [31:0] d);
        apb(1'b0, i, 32'h0, {2'b10, d});
    endtask : rd

    task automatic set_timer(input logic [15:0] v);
        load_val <= v;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
    endtask : set_timer

    initial
    begin
        {presetn, psel, penable, pwrite, load, run} = 6'h00;
        {paddr, pwdata, load_val} = 56'h0;
        {ce, port_direction, port_data_latch} = 3'b110;
        void'($urandom(43716));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CT, 32'h0);
        rd(LO, 32'h0);
        rd(ST, 32'h0);
        wr(CT, 32'hFF);
        rd(CT, 32'h3F);
        apb(1'b1, 8'h1F, 32'hFF, {2'b01, 32'h0});
        apb(1'b0, 8'h1F, 32'h0, {2'b11, 32'h0});
        t = 16'($urandom);
        wr(HI, {24'h0, t[7:0]});
        rd(HI, {24'h0, t[7:0]});
        chk(32'(unit_pin_oe_n), 32'h1);
        $display("Test registers done");
        for (int k = 0; k < 4; k++)
        begin
            n = (k == 2) ? 4 : (k == 3) ? 16 : 1;
            wr(CT, 32'h0);
            tccu_pin_src_inst.pulses(2);
            wr(CT, {28'h0, tccu_pkg::MODE_CAP_FALL + 4'(k)});
            wr(ST, 32'h1);
            for (int r = 0; r < 2; r++)
            begin
                t = 16'($urandom);
                set_timer(t);
                tccu_pin_src_inst.pulses(n - 1);
                rd(ST, 32'(r));
                tccu_pin_src_inst.pulses(1);
                rd(ST, 32'h1);
                rd(LO, {24'h0, t[7:0]});
                rd(HI, {24'h0, t[15:8]});
            end
        end
        $display("Test capture done");
        wr(CT, 32'h0);
        port_direction <= 1'b0;
        wr(CT, {28'h0, tccu_pkg::MODE_CAP_RISE});
        wr(ST, 32'h1);
        t = 16'($urandom);
        set_timer(t);
        port_data_latch <= 1'b1;
        repeat (4) @(posedge pclk);
        port_data_latch <= 1'b0;
        rd(ST, 32'h1);
        rd(LO, {24'h0, t[7:0]});
        $display("Test port latch done");
        c = 16'h0100 + 16'($urandom % 32'hFE00);
        wr(LO, {24'h0, c[7:0]});
        wr(HI, {24'h0, c[15:8]});
        wr(CT, 32'h0);
        set_timer(16'h0000);
        for (int k = 0; k < 5; k++)
        begin
            wr(CT, {28'h0, MD[k]});
            wr(ST, 32'h1);
            set_timer(c - 16'h0008);
            run <= 1'b1;
            n = 0;
            while (unit_event_flag !== 1'b1 && n < 40)
            begin
                @(posedge pclk);
                n++;
            end
            run <= 1'b0;
            chk(32'(unit_event_flag), 32'h1);
            if (k != 3)
                chk(32'(unit_pin_out), 32'(PX[k]));
        end
        repeat (2) @(posedge pclk);
        chk(32'(trig_cnt), 32'h1);
        wr(CT, 32'h0);
        wr(CT, {28'h0, tccu_pkg::MODE_CMP_SOFT});
        @(posedge pclk);
        chk(32'(unit_pin_out), 32'h0);
        chk(32'(unit_pin_oe_n), 32'h0);
        $display("Test compare done");
        report_and_stop();
    end
endmodule : tccu_bench
